/* common/ald_map.vh */
// Purpose: constants for the arithmetic/logic opcode decoder
// Assumes: 8-bit opcodes, cycle counts in system clock cycles
// Notes:   definitions only
`ifndef ALD_MAP_VH
`define ALD_MAP_VH
// operation codes
`define ALD_OP_NONE   4'h0
`define ALD_OP_ADD    4'h1
`define ALD_OP_ADD_CY 4'h2
`define ALD_OP_SUB_BRW 4'h3
`define ALD_OP_INC    4'h4
`define ALD_OP_MINUS1 4'h5
`define ALD_OP_AND    4'h6
`define ALD_OP_OR     4'h7
`define ALD_OP_XOR    4'h8
`define ALD_OP_ROT_L  4'h9
`define ALD_OP_ROT_R  4'hA
`define ALD_OP_INCDP  4'hB
// operand source codes
`define ALD_SRC_NONE  3'h0
`define ALD_SRC_ACC   3'h1
`define ALD_SRC_REG   3'h2
`define ALD_SRC_DIR   3'h3
`define ALD_SRC_IND   3'h4
`define ALD_SRC_IMM   3'h5
// destination codes
`define ALD_DST_ACC   2'h0
`define ALD_DST_REG   2'h1
`define ALD_DST_DIR   2'h2
`define ALD_DST_IND   2'h3
// cycle counts
`define ALD_CYC_SHORT 4'h2
`define ALD_CYC_LONG  4'h4
`define ALD_CYC_UNDEF 4'h1
// lengths
`define ALD_LEN_1     2'h1
`define ALD_LEN_2     2'h2
`define ALD_LEN_3     2'h3
`endif

/* rtl/ald_byte_reg.v */
// Purpose: small register store for fetched instruction bytes
// Assumes: one write port, registered read
// Notes:   holds opcode and up to two operand bytes
`timescale 1ns/1ps
module ald_byte_reg (
  clk,
  rst_b,
  wr_en,
  wr_idx,
  wr_data,
  rd_idx,
  rd_data
);
  input        clk;
  input        rst_b;
  input        wr_en;
  input  [1:0] wr_idx;
  input  [7:0] wr_data;
  input  [1:0] rd_idx;
  output [7:0] rd_data;
  reg    [7:0] mem_ff [0:2]; // byte slots
  reg    [7:0] rd_data_ff;   // registered read
  assign rd_data = rd_data_ff;
  // write slots and register the read
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_ff[0]  <= 8'h00;
      mem_ff[1]  <= 8'h00;
      mem_ff[2]  <= 8'h00;
      rd_data_ff <= 8'h00;
    end else begin
      if (wr_en && wr_idx != 2'h3) begin
        mem_ff[wr_idx] <= wr_data;
      end
      rd_data_ff <= (rd_idx == 2'h3) ? 8'h00 : mem_ff[rd_idx];
    end
  end
endmodule

/* rtl/ald_decoder.v */
// Purpose: decode arithmetic and logical opcodes, fetch operands, time execution
// Assumes: program memory answers a fetch request one cycle later with valid data
// Notes:   other instruction groups decode as op none, length 1, one cycle
`timescale 1ns/1ps
`include "ald_map.vh"
// What this block does
// - fetch one to three bytes per opcode
// - fixed opcode-dependent execution cycle count
// - add opcodes 28-2F,25,26-27,24 two cycles
// - add-with-carry 38-3F,35,36-37,34 two cycles
// - subtract-borrow 98-9F,95,96-97,94 two cycles
// - plus-one 04,08-0F,05,06-07 two cycles
// - minus-one 14,18-1F,15,16-17 two cycles
// - data pointer increment A3, four cycles
// - and into accumulator 58-5F,55,56-57,54
// - and into direct 52 two, 53 four
// - or into accumulator 48-4F,45,46-47,44
// - or into direct 42 two, 43 four
// - xor into accumulator 68-6F,65,66-67,64
// - xor into direct 62 two, 63 four
// - rotate left through carry 33, two cycles
// - rotate right through carry 13, two cycles
// - low three bits select bank register
module ald_decoder (
  clk,
  rst_b,
  fetch_req,
  fetch_data,
  fetch_valid,
  exec_done,
  op_code,
  op_src,
  op_dst,
  bank_reg_n,
  pointer_reg_i,
  op_len,
  op_cycles,
  operand1,
  operand2,
  op_valid,
  busy
);
  input        clk;           // 40 MHz system clock
  input        rst_b;         // async reset, active low
  output       fetch_req;     // request next program byte
  input  [7:0] fetch_data;    // byte from program memory
  input        fetch_valid;   // byte present this cycle
  output       exec_done;     // pulse at end of execution
  output [3:0] op_code;       // decoded operation
  output [2:0] op_src;        // operand source
  output [1:0] op_dst;        // destination
  output [2:0] bank_reg_n;    // selected bank register
  output       pointer_reg_i; // selected pointer register
  output [1:0] op_len;        // instruction length in bytes
  output [3:0] op_cycles;     // execution cycles
  output [7:0] operand1;      // first operand byte
  output [7:0] operand2;      // second operand byte
  output       op_valid;      // decode fields valid (level)
  output       busy;          // instruction in progress

  // states
  localparam ST_OPC  = 2'h0;
  localparam ST_OPND = 2'h1;
  localparam ST_EXEC = 2'h2;
  localparam ST_DONE = 2'h3;

  reg  [1:0] state_ff;
  reg  [1:0] nxt_state;
  reg        fetch_req_ff;
  reg        exec_done_ff;
  reg  [3:0] op_code_ff;
  reg  [2:0] op_src_ff;
  reg  [1:0] op_dst_ff;
  reg  [2:0] bank_reg_n_ff;
  reg        pointer_reg_i_ff;
  reg  [1:0] op_len_ff;
  reg  [3:0] op_cycles_ff;
  reg  [7:0] operand1_ff;
  reg  [7:0] operand2_ff;
  reg        op_valid_ff;
  reg  [1:0] byte_cnt_ff;     // operand bytes taken
  reg  [3:0] cyc_cnt_ff;      // execution cycles left
  reg  [1:0] rd_idx_ff;       // store read index
  wire [7:0] store_rd;        // store read data
  reg         busy_ff;        // instruction in progress
  wire [14:0] dec_fields;     // decode of fetched opcode

  // decode table: {op, src, dst, len, cycles}
  function [14:0] ald_decode;
    input [7:0] opc;
    reg   [3:0] op;
    reg   [2:0] src;
    reg   [1:0] dst;
    reg   [1:0] len;
    reg   [3:0] cyc;
    begin
      op  = `ALD_OP_NONE;
      src = `ALD_SRC_NONE;
      dst = `ALD_DST_ACC;
      len = `ALD_LEN_1;
      cyc = `ALD_CYC_UNDEF;
      // arithmetic, logic, plus-one and minus-one groups by high nibble
      case (opc[7:4])
        4'h2: op = `ALD_OP_ADD;
        4'h3: op = `ALD_OP_ADD_CY;
        4'h9: op = `ALD_OP_SUB_BRW;
        4'h5: op = `ALD_OP_AND;
        4'h4: op = `ALD_OP_OR;
        4'h6: op = `ALD_OP_XOR;
        4'h0: op = `ALD_OP_INC;
        4'h1: op = `ALD_OP_MINUS1;
        default: op = `ALD_OP_NONE;
      endcase
      if (op != `ALD_OP_NONE) begin
        cyc = `ALD_CYC_SHORT;
        if (opc[3]) begin
          src = `ALD_SRC_REG;
          if (op == `ALD_OP_INC || op == `ALD_OP_MINUS1) dst = `ALD_DST_REG;
        end else begin
          case (opc[2:0])
            3'h4: begin
              if (op == `ALD_OP_INC || op == `ALD_OP_MINUS1) begin
                src = `ALD_SRC_ACC;
              end else begin
                src = `ALD_SRC_IMM;
                len = `ALD_LEN_2;
              end
            end
            3'h5: begin
              src = `ALD_SRC_DIR;
              len = `ALD_LEN_2;
              if (op == `ALD_OP_INC || op == `ALD_OP_MINUS1) dst = `ALD_DST_DIR;
            end
            3'h6, 3'h7: begin
              src = `ALD_SRC_IND;
              if (op == `ALD_OP_INC || op == `ALD_OP_MINUS1) dst = `ALD_DST_IND;
            end
            3'h2: begin
              // logic into direct byte, accumulator source
              if (op == `ALD_OP_AND || op == `ALD_OP_OR || op == `ALD_OP_XOR) begin
                src = `ALD_SRC_ACC;
                dst = `ALD_DST_DIR;
                len = `ALD_LEN_2;
              end else begin
                op  = `ALD_OP_NONE;
                cyc = `ALD_CYC_UNDEF;
              end
            end
            3'h3: begin
              if (op == `ALD_OP_AND || op == `ALD_OP_OR || op == `ALD_OP_XOR) begin
                src = `ALD_SRC_IMM;
                dst = `ALD_DST_DIR;
                len = `ALD_LEN_3;
                cyc = `ALD_CYC_LONG;
              end else if (opc == 8'h33) begin
                op  = `ALD_OP_ROT_L;
                src = `ALD_SRC_ACC;
              end else if (opc == 8'h13) begin
                op  = `ALD_OP_ROT_R;
                src = `ALD_SRC_ACC;
              end else begin
                op  = `ALD_OP_NONE;
                cyc = `ALD_CYC_UNDEF;
              end
            end
            default: begin
              op  = `ALD_OP_NONE;
              cyc = `ALD_CYC_UNDEF;
            end
          endcase
        end
      end else if (opc == 8'hA3) begin
        op  = `ALD_OP_INCDP;
        cyc = `ALD_CYC_LONG;
      end
      if (op == `ALD_OP_NONE) begin
        src = `ALD_SRC_NONE;
        dst = `ALD_DST_ACC;
      end
      ald_decode = {op, src, dst, len, cyc};
    end
  endfunction

  assign dec_fields = ald_decode(fetch_data);

  // opcode/operand store, slot 0 opcode
  ald_byte_reg u_store (
    .wr_en   (fetch_valid && state_ff != ST_EXEC && state_ff != ST_DONE),
    .clk     (clk),
    .rst_b   (rst_b),
    .wr_idx  ((state_ff == ST_OPC) ? 2'h0 : (byte_cnt_ff + 2'h1)),
    .wr_data (fetch_data),
    .rd_idx  (rd_idx_ff),
    .rd_data (store_rd)
  );

  assign fetch_req     = fetch_req_ff;
  assign exec_done     = exec_done_ff;
  assign op_code       = op_code_ff;
  assign op_src        = op_src_ff;
  assign op_dst        = op_dst_ff;
  assign bank_reg_n    = bank_reg_n_ff;
  assign pointer_reg_i = pointer_reg_i_ff;
  assign op_len        = op_len_ff;
  assign op_cycles     = op_cycles_ff;
  assign operand1      = operand1_ff;
  assign operand2      = operand2_ff;
  assign op_valid      = op_valid_ff;
  assign busy          = busy_ff;

  // next state
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_OPC: begin
        if (fetch_valid) begin
          nxt_state = (dec_fields[5:4] == `ALD_LEN_1) ? ST_EXEC : ST_OPND;
        end
      end
      ST_OPND: begin
        if (fetch_valid && (byte_cnt_ff + 2'h2) == op_len_ff) nxt_state = ST_EXEC;
      end
      ST_EXEC: begin
        if (cyc_cnt_ff == 4'h1) nxt_state = ST_DONE;
      end
      ST_DONE: nxt_state = ST_OPC;
      default: nxt_state = ST_OPC;
    endcase
  end

  // sequencing and decode registers
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff         <= ST_OPC;
      fetch_req_ff     <= 1'b0;
      exec_done_ff     <= 1'b0;
      op_code_ff       <= `ALD_OP_NONE;
      op_src_ff        <= `ALD_SRC_NONE;
      op_dst_ff        <= `ALD_DST_ACC;
      bank_reg_n_ff    <= 3'h0;
      pointer_reg_i_ff <= 1'b0;
      op_len_ff        <= `ALD_LEN_1;
      op_cycles_ff     <= `ALD_CYC_UNDEF;
      operand1_ff      <= 8'h00;
      operand2_ff      <= 8'h00;
      op_valid_ff      <= 1'b0;
      byte_cnt_ff      <= 2'h0;
      cyc_cnt_ff       <= 4'h0;
      rd_idx_ff        <= 2'h0;
      busy_ff          <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      exec_done_ff <= 1'b0;
      // request bytes while fetching, stop once complete
      fetch_req_ff <= (nxt_state == ST_OPC || nxt_state == ST_OPND) ? 1'b1 : 1'b0;
      busy_ff      <= (nxt_state != ST_OPC) ? 1'b1 : 1'b0;
      case (state_ff)
        ST_OPC: begin
          if (fetch_valid) begin
            op_code_ff       <= dec_fields[14:11];
            op_src_ff        <= dec_fields[10:8];
            op_dst_ff        <= dec_fields[7:6];
            op_len_ff        <= dec_fields[5:4];
            op_cycles_ff     <= dec_fields[3:0];
            bank_reg_n_ff    <= fetch_data[2:0];
            pointer_reg_i_ff <= fetch_data[0];
            byte_cnt_ff      <= 2'h0;
            cyc_cnt_ff       <= dec_fields[3:0];
            operand1_ff      <= 8'h00;
            operand2_ff      <= 8'h00;
            op_valid_ff      <= 1'b0;
            rd_idx_ff        <= 2'h0;
          end
        end
        ST_OPND: begin
          if (fetch_valid) begin
            // operand bytes follow the opcode in order
            if (byte_cnt_ff == 2'h0) operand1_ff <= fetch_data;
            else operand2_ff <= fetch_data;
            byte_cnt_ff <= byte_cnt_ff + 2'h1;
          end
        end
        ST_EXEC: begin
          op_valid_ff <= 1'b1;
          cyc_cnt_ff  <= cyc_cnt_ff - 4'h1;
          rd_idx_ff   <= 2'h0;
        end
        ST_DONE: begin
          exec_done_ff <= 1'b1;
          op_valid_ff  <= 1'b0;
        end
        default: begin
          op_valid_ff <= 1'b0;
        end
      endcase
    end
  end
endmodule

/* bench/ald_decoder_sva.sv */
// Purpose: port assertions for the opcode decoder
// Assumes: one clock domain, async active-low reset
// Notes:   bound to every decoder instance
`timescale 1ns/1ps
`include "ald_map.vh"
module ald_decoder_sva (
  input logic       clk,
  input logic       rst_b,
  input logic       fetch_req,
  input logic [7:0] fetch_data,
  input logic       fetch_valid,
  input logic       exec_done,
  input logic [3:0] op_code,
  input logic [2:0] op_src,
  input logic [2:0] bank_reg_n,
  input logic       pointer_reg_i,
  input logic [1:0] op_len,
  input logic [3:0] op_cycles,
  input logic       op_valid,
  input logic       busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire take = fetch_valid && fetch_req && !busy; // opcode accepted on this edge
  cyc_one_a: assert property ($rose(op_valid) && op_cycles == 4'h1 |-> op_valid ##1 !op_valid && exec_done)
    else $error("one-cycle execution length wrong");
  cyc_two_a: assert property ($rose(op_valid) && op_cycles == 4'h2 |-> op_valid[*2] ##1 !op_valid && exec_done)
    else $error("two-cycle execution length wrong");
  cyc_four_a: assert property ($rose(op_valid) && op_cycles == 4'h4 |-> op_valid[*4] ##1 !op_valid && exec_done)
    else $error("four-cycle execution length wrong");
  done_pulse_a: assert property (exec_done |=> !exec_done && !op_valid)
    else $error("done pulse longer than one cycle");
  add_imm_a: assert property (take && fetch_data == 8'h24 |=> op_code == `ALD_OP_ADD && op_src == `ALD_SRC_IMM)
    else $error("immediate add decoded wrongly");
  dp_inc_a: assert property (take && fetch_data == 8'ha3 |=> op_code == `ALD_OP_INCDP && op_cycles == `ALD_CYC_LONG)
    else $error("pointer increment decoded wrongly");
  bank_select_a: assert property (take ##1 op_src == `ALD_SRC_REG |-> bank_reg_n == $past(fetch_data[2:0]))
    else $error("bank register select wrong");
  ptr_select_a: assert property (take ##1 op_src == `ALD_SRC_IND |-> pointer_reg_i == $past(fetch_data[0]))
    else $error("pointer register select wrong");
  short_len_a: assert property (take ##1 op_len == `ALD_LEN_1 |-> !fetch_req ##1 op_valid)
    else $error("single-byte opcode kept fetching");
  long_len_a: assert property (take ##1 op_len != `ALD_LEN_1 |-> fetch_req && !op_valid)
    else $error("operand fetch skipped");
endmodule
bind ald_decoder ald_decoder_sva chk (.clk(clk), .rst_b(rst_b), .fetch_req(fetch_req), .fetch_data(fetch_data),
  .fetch_valid(fetch_valid), .exec_done(exec_done), .op_code(op_code), .op_src(op_src), .bank_reg_n(bank_reg_n),
  .pointer_reg_i(pointer_reg_i), .op_len(op_len), .op_cycles(op_cycles), .op_valid(op_valid), .busy(busy));

/* bench/ald_prog_mem.sv */
// Purpose: program memory model feeding instruction bytes
// Assumes: answers a fetch request one edge later, may stall
// Notes:   idle data bus inverts on every edge, alternating between the inverse of its last byte and that byte
`timescale 1ns/1ps
module ald_prog_mem (
  input  logic       clk,
  input  logic       rst_b,
  input  logic       fetch_req,
  input  logic       stall,
  output logic       fetch_valid,
  output logic [7:0] fetch_data
);
  logic [7:0] q[$]; // bytes still to hand out
  // one byte per edge while requested and not stalled
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fetch_valid <= 1'b0;
      fetch_data  <= 8'h00;
    end else if (fetch_req && !stall && q.size() > 0) begin
      fetch_valid <= 1'b1;
      fetch_data  <= q.pop_front();
    end else begin
      fetch_valid <= 1'b0;
      fetch_data  <= ~fetch_data; // released bus inverts on each idle edge
    end
  end
endmodule

/* bench/test_ald_decoder.sv */
// Purpose: self-checking bench for the opcode decoder
// Assumes: memory model feeds bytes with random stalls
// Notes:   every opcode value is decoded against a reference model, 53 again after a mid-fetch reset
`timescale 1ns/1ps
`include "ald_map.vh"
module test_ald_decoder;
  logic        clk = 1'b0;              // system clock
  logic        rst_b = 1'b0;            // reset, active low
  logic        stall_ff = 1'b0;         // memory wait request
  logic [31:0] rnd_ff = 32'h0000_bad6;  // lfsr state
  wire         fetch_req, fetch_valid, exec_done, pointer_reg_i, op_valid, busy;
  wire  [7:0]  fetch_data, operand1, operand2;
  wire  [3:0]  op_code, op_cycles;
  wire  [2:0]  op_src, bank_reg_n;
  wire  [1:0]  op_dst, op_len;
  int          errors = 0, n_checks = 0, e_op, e_src, e_dst, e_len, e_cyc, k, a;
  logic [7:0]  b1, b2;                  // operand bytes of current test
  always #12.5 clk = ~clk;
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // random stalls of the memory side
  always @(posedge clk) begin
    rnd_ff   <= lfsr(rnd_ff);
    stall_ff <= rnd_ff[3] & rnd_ff[0];
  end
  ald_prog_mem mem (.clk(clk), .rst_b(rst_b), .fetch_req(fetch_req), .stall(stall_ff),
    .fetch_valid(fetch_valid), .fetch_data(fetch_data));
  ald_decoder dut (.clk(clk), .rst_b(rst_b), .fetch_req(fetch_req), .fetch_data(fetch_data),
    .fetch_valid(fetch_valid), .exec_done(exec_done), .op_code(op_code), .op_src(op_src), .op_dst(op_dst),
    .bank_reg_n(bank_reg_n), .pointer_reg_i(pointer_reg_i), .op_len(op_len), .op_cycles(op_cycles),
    .operand1(operand1), .operand2(operand2), .op_valid(op_valid), .busy(busy));
  task cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // reference decode; -1 marks a field left open
  task model(input logic [7:0] opc);
    int hi, lo;
    hi = opc[7:4];
    lo = opc[3:0];
    e_op = 0; e_src = -1; e_dst = -1; e_len = 1; e_cyc = 1;
    case (hi)
      0: a = 4; 1: a = 5; 2: a = 1; 3: a = 2; 4: a = 7; 5: a = 6; 6: a = 8; 9: a = 3;
      default: a = 0;
    endcase
    if (a != 0 && lo >= 4) begin
      e_op = a; e_cyc = 2; e_dst = 0;
      e_src = lo >= 8 ? 2 : lo == 4 ? 5 : lo == 5 ? 3 : 4;
      e_len = (lo == 4 || lo == 5) ? 2 : 1;
      if (hi < 2) begin
        if (lo == 4) e_src = 1;
        e_dst = e_src - 1;
        e_len = lo == 5 ? 2 : 1;
      end
    end else if (a >= 6 && lo == 2) begin
      e_op = a; e_src = 1; e_dst = 2; e_len = 2; e_cyc = 2;
    end else if (a >= 6 && lo == 3) begin
      e_op = a; e_src = 5; e_dst = 2; e_len = 3; e_cyc = 4;
    end else if (opc == 8'h33 || opc == 8'h13) begin
      e_op = hi == 3 ? 9 : 10; e_cyc = 2;
      e_src = 1;
      e_dst = 0;
    end else if (opc == 8'ha3) begin
      e_op = 11; e_cyc = 4;
      e_src = 0;
    end
  endtask
  // one instruction through memory, decode and execution
  task run(input logic [7:0] opc);
    model(opc);
    b1 = rnd_ff[15:8];
    b2 = rnd_ff[23:16];
    mem.q.delete();
    mem.q.push_back(opc);
    if (e_len > 1) mem.q.push_back(b1);
    if (e_len > 2) mem.q.push_back(b2);
    k = 0;
    while (op_valid !== 1'b1 && k < 60) begin
      @(negedge clk);
      k++;
    end
    if (op_valid !== 1'b1) begin
      $display("[FAIL] op_valid expected 1 seen timeout");
      errors++;
      conclude();
    end
    cmp("op_code", 8'(e_op), {4'h0, op_code});
    cmp("op_len", 8'(e_len), {6'h00, op_len});
    cmp("op_cycles", 8'(e_cyc), {4'h0, op_cycles});
    if (e_src >= 0) cmp("op_src", 8'(e_src), {5'h00, op_src});
    if (e_dst >= 0) cmp("op_dst", 8'(e_dst), {6'h00, op_dst});
    if (e_src == 2) cmp("bank_reg_n", {5'h00, opc[2:0]}, {5'h00, bank_reg_n});
    if (e_src == 4) cmp("pointer_reg_i", {7'h00, opc[0]}, {7'h00, pointer_reg_i});
    cmp("operand1", e_len > 1 ? b1 : 8'h00, operand1);
    cmp("operand2", e_len > 2 ? b2 : 8'h00, operand2);
    cmp("busy", 8'h01, {7'h00, busy});
    k = 0;
    while (op_valid === 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    cmp("exec length", 8'(e_cyc), 8'(k));
    cmp("exec_done", 8'h01, {7'h00, exec_done});
    cmp("busy idle", 8'h00, {7'h00, busy});
    @(negedge clk);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    for (int i = 0; i < 256; i++) run(i[7:0]);
    $display("opcode sweep done");
    // reset in the middle of a three-byte fetch
    mem.q.push_back(8'h53);
    repeat (3) @(posedge clk);
    rst_b <= 1'b0;
    @(negedge clk);
    cmp("op_cycles in reset", 8'h01, {4'h0, op_cycles});
    cmp("op_valid in reset", 8'h00, {7'h00, op_valid});
    cmp("fetch_req in reset", 8'h00, {7'h00, fetch_req});
    @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    run(8'h53);
    $display("mid-fetch reset done");
    conclude();
  end
endmodule
